// file: src/otq_otp_cfi.sv
// command decoder for one-time registers, lock words, status and query reads
// assumes a controller on ref_clk_i gives one-cycle read and write strobes with word addresses
`include "otq_regs.svh"

module otq_otp_cfi import otq_pkg::*; #(
  parameter logic [7:0] DENSITY_LOG2 = 8'h19,
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic rdata_valid_o,
  output logic status_program_error_o,
  output logic status_lock_error_o
);

  // ************************************************
  // declarations
  // ************************************************
  otq_state_t st;
  otq_state_t next_st;

  logic [15:0] rd_off;
  logic [15:0] cmd_off;
  logic rd_in_region;
  logic wr_in_region;
  logic [7:0] rd_idx;
  logic [7:0] cmd_idx;
  logic [7:0] upper_rel;
  logic [3:0] upper_sel;
  logic target_locked;
  logic mem_wr;
  logic [15:0] mem_rdata;
  logic [15:0] lock0;
  logic [15:0] lock1;
  logic [15:0] status_word;
  logic [15:0] query_word;
  logic [7:0] query_k;
  logic set_perr;
  logic set_lerr;
  logic clr_err;

  // ************************************************
  // address decode
  // ************************************************
  assign rd_off = addr_i - `OTQ_REGION_BASE;
  assign cmd_off = addr_i - `OTQ_REGION_BASE;
  assign rd_in_region = (rd_off >= `OTQ_LOCK0_OFS) && (rd_off <= `OTQ_OTP_LAST_OFS);
  assign wr_in_region = (cmd_off >= `OTQ_LOCK0_OFS) && (cmd_off <= `OTQ_OTP_LAST_OFS);
  // lock word 0, register 0, lock word 1 and the sixteen registers sit back to back
  assign rd_idx = 8'(rd_off - `OTQ_LOCK0_OFS);
  assign cmd_idx = 8'(st.cmd_addr - `OTQ_REGION_BASE - `OTQ_LOCK0_OFS);
  assign upper_rel = cmd_idx - `OTQ_UPPER_FIRST;
  assign upper_sel = upper_rel[6:3];

  // ************************************************
  // lock lookup
  // ************************************************
  // lock words themselves are never locked, so more bits can always be cleared in them
  always_comb begin
    target_locked = 1'b0;
    if (cmd_idx >= `OTQ_UPPER_FIRST) begin
      target_locked = !lock1[upper_sel];
    end else if (cmd_idx >= `OTQ_HIGH_SEG_FIRST && cmd_idx < `OTQ_LOCK1_IDX) begin
      target_locked = !lock0[`OTQ_LOCK0_HIGH_BIT];
    end else if (cmd_idx >= `OTQ_LOW_SEG_FIRST && cmd_idx < `OTQ_HIGH_SEG_FIRST) begin
      target_locked = !lock0[`OTQ_LOCK0_LOW_BIT];
    end
  end

  // ************************************************
  // status and query words
  // ************************************************
  always_comb begin
    status_word = 16'h0000;
    status_word[`OTQ_SR_READY_BIT] = 1'b1;
    status_word[`OTQ_SR_PROG_ERR_BIT] = st.prog_err;
    status_word[`OTQ_SR_LOCK_ERR_BIT] = st.lock_err;
  end

  assign query_k = 8'(rd_off - `OTQ_CFI_FIRST);

  // only the identification, interface and first geometry words are held; the rest read as zero
  always_comb begin
    query_word = 16'h0000;
    if (rd_off == `OTQ_CFI_GEOM) begin
      query_word[7:0] = DENSITY_LOG2;
    end else if (rd_off >= `OTQ_CFI_FIRST && rd_off <= `OTQ_CFI_LAST) begin
      query_word[7:0] = 8'(`OTQ_CFI_TABLE >> {query_k, 3'b000});
    end
  end

  // ************************************************
  // command decode and read path
  // ************************************************
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    mem_wr = 1'b0;
    set_perr = 1'b0;
    set_lerr = 1'b0;
    clr_err = 1'b0;
    if (wr_en_i) begin
      if (st.mode == OTQ_PROG_DATA) begin
        next_st.mode = OTQ_STATUS;
        if (!st.bad) begin
          if (addr_i != st.cmd_addr) begin
            set_perr = 1'b1;
          end else if (target_locked) begin
            set_perr = 1'b1;
            set_lerr = 1'b1;
          end else begin
            mem_wr = 1'b1;
          end
        end
      end else begin
        case (wdata_i[7:0])
          `OTQ_CMD_READ_ARRAY: begin
            next_st.mode = OTQ_ARRAY;
          end
          `OTQ_CMD_READ_ID: begin
            next_st.mode = OTQ_IDENT;
          end
          `OTQ_CMD_READ_QUERY: begin
            next_st.mode = OTQ_QUERY;
          end
          `OTQ_CMD_READ_STATUS: begin
            next_st.mode = OTQ_STATUS;
          end
          `OTQ_CMD_CLEAR_STATUS: begin
            clr_err = 1'b1;
          end
          `OTQ_CMD_PROGRAM_OTP: begin
            next_st.mode = OTQ_PROG_DATA;
            next_st.cmd_addr = addr_i;
            next_st.bad = !wr_in_region;
            set_perr = !wr_in_region;
          end
          default: begin
          end
        endcase
      end
    end
    // set wins over clear; here both cannot come from one write anyway
    next_st.prog_err = (st.prog_err & !clr_err) | set_perr;
    next_st.lock_err = (st.lock_err & !clr_err) | set_lerr;
    if (rd_en_i) begin
      next_st.rvalid = 1'b1;
      case (st.mode)
        OTQ_IDENT: begin
          next_st.rdata = rd_in_region ? mem_rdata : 16'h0000;
        end
        OTQ_QUERY: begin
          next_st.rdata = query_word;
        end
        OTQ_STATUS, OTQ_PROG_DATA: begin
          next_st.rdata = status_word;
        end
        OTQ_ARRAY: begin
          next_st.rdata = `OTQ_ARRAY_READ;
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '{mode: OTQ_ARRAY, cmd_addr: 16'h0000, bad: 1'b0, prog_err: 1'b0,
              lock_err: 1'b0, rdata: 16'h0000, rvalid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ************************************************
  // store
  // ************************************************
  otq_store #(
    .UNIQUE_ID(UNIQUE_ID)
  ) u_store (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_i(mem_wr),
    .waddr_i(cmd_idx),
    .wdata_i(wdata_i),
    .raddr_i(rd_idx),
    .rdata_o(mem_rdata),
    .lock0_o(lock0),
    .lock1_o(lock1)
  );

  assign rdata_o = st.rdata;
  assign rdata_valid_o = st.rvalid;
  assign status_program_error_o = st.prog_err;
  assign status_lock_error_o = st.lock_err;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  lock_err_pair_a: assert property (
    status_lock_error_o |-> status_program_error_o)
    else $error("lock error without program error");

  locked_no_write_a: assert property (
    wr_en_i && st.mode == OTQ_PROG_DATA && !st.bad && addr_i == st.cmd_addr && target_locked
    |-> !mem_wr ##1 (status_program_error_o && status_lock_error_o))
    else $error("locked register was programmed or errors missing");

  outside_cmd_a: assert property (
    wr_en_i && st.mode != OTQ_PROG_DATA && wdata_i[7:0] == `OTQ_CMD_PROGRAM_OTP && !wr_in_region
    |=> status_program_error_o && st.mode == OTQ_PROG_DATA && st.bad)
    else $error("program command outside region did not flag error");

  query_upper_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY |=> rdata_valid_o && rdata_o[15:8] == 8'h00)
    else $error("query read drove the upper byte");

  query_string_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY && rd_off == `OTQ_CFI_FIRST |=> rdata_o == 16'h0051)
    else $error("query string does not start with Q");

  ident_read_a: assert property (
    rd_en_i && st.mode == OTQ_IDENT && rd_in_region |=> rdata_o == $past(mem_rdata))
    else $error("identifier read returned wrong register word");

  mode_hold_a: assert property (
    st.mode inside {OTQ_IDENT, OTQ_QUERY} && !wr_en_i |=> st.mode == $past(st.mode))
    else $error("read mode changed without a command");

  factory_lock_a: assert property (
    !lock0[`OTQ_LOCK0_LOW_BIT])
    else $error("factory lock bit reads unprogrammed");

  upper_lock_a: assert property (
    mem_wr && cmd_idx >= `OTQ_UPPER_FIRST |-> lock1[upper_sel])
    else $error("write reached a register whose lock bit is programmed");

  read_answer_a: assert property (
    rd_en_i |=> rdata_valid_o ##1 (!rdata_valid_o || $past(rd_en_i)))
    else $error("read answer not a one-cycle pulse");

  // ************************************************
  // read answers per mode
  // ************************************************
  valid_needs_read_a: assert property (
    rdata_valid_o |-> $past(rd_en_i))
    else $error("read answer without a read strobe");

  status_ready_a: assert property (
    rd_en_i && st.mode == OTQ_STATUS |=> rdata_o[`OTQ_SR_READY_BIT])
    else $error("status read shows device busy");

  status_perr_a: assert property (
    rd_en_i && st.mode inside {OTQ_STATUS, OTQ_PROG_DATA} |=> rdata_o[`OTQ_SR_PROG_ERR_BIT] == $past(st.prog_err))
    else $error("status read misreports program error");

  status_lerr_a: assert property (
    rd_en_i && st.mode inside {OTQ_STATUS, OTQ_PROG_DATA} |=> rdata_o[`OTQ_SR_LOCK_ERR_BIT] == $past(st.lock_err))
    else $error("status read misreports lock error");

  array_read_a: assert property (
    rd_en_i && st.mode == OTQ_ARRAY |=> rdata_o == `OTQ_ARRAY_READ)
    else $error("array mode read returned wrong word");

  ident_outside_a: assert property (
    rd_en_i && st.mode == OTQ_IDENT && !rd_in_region |=> rdata_o == 16'h0000)
    else $error("identifier read outside region not zero");

  query_r_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY && rd_off == 16'h0011 |=> rdata_o == 16'h0052)
    else $error("second query string byte wrong");

  query_y_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY && rd_off == 16'h0012 |=> rdata_o == 16'h0059)
    else $error("third query string byte wrong");

  query_vendor_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY && rd_off == 16'h0013 |=> rdata_o == 16'h0001)
    else $error("primary identifier low byte wrong");

  query_alt_zero_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY && rd_off inside {[16'h0017:16'h001A]} |=> rdata_o == 16'h0000)
    else $error("alternate identifier or table address not zero");

  query_geom_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY && rd_off == `OTQ_CFI_GEOM |=> rdata_o == {8'h00, DENSITY_LOG2})
    else $error("geometry size byte wrong");

  query_outside_a: assert property (
    rd_en_i && st.mode == OTQ_QUERY && !(rd_off inside {[`OTQ_CFI_FIRST:`OTQ_CFI_LAST]}) |=> rdata_o == 16'h0000)
    else $error("query read outside table not zero");

  // ************************************************
  // program sequence
  // ************************************************
  // the data write is judged against the address latched with the command
  prog_cmd_mode_a: assert property (
    wr_en_i && st.mode != OTQ_PROG_DATA && wdata_i[7:0] == `OTQ_CMD_PROGRAM_OTP
    |=> st.mode == OTQ_PROG_DATA && st.cmd_addr == $past(addr_i))
    else $error("program command not latched");

  data_to_status_a: assert property (
    wr_en_i && st.mode == OTQ_PROG_DATA |=> st.mode == OTQ_STATUS)
    else $error("data write did not return to status mode");

  addr_mismatch_a: assert property (
    wr_en_i && st.mode == OTQ_PROG_DATA && !st.bad && addr_i != st.cmd_addr
    |-> !mem_wr ##1 status_program_error_o)
    else $error("data at a different address was not refused");

  bad_swallow_a: assert property (
    wr_en_i && st.mode == OTQ_PROG_DATA && st.bad |-> !mem_wr)
    else $error("data after an outside command reached the store");

  good_prog_a: assert property (
    wr_en_i && st.mode == OTQ_PROG_DATA && !st.bad && addr_i == st.cmd_addr && !target_locked |-> mem_wr)
    else $error("unlocked program did not reach the store");

  wr_in_store_a: assert property (
    mem_wr |-> cmd_idx <= 8'h89)
    else $error("store write beyond the seventeen registers");

  high_seg_lock_a: assert property (
    mem_wr && cmd_idx >= `OTQ_HIGH_SEG_FIRST && cmd_idx < `OTQ_LOCK1_IDX |-> lock0[`OTQ_LOCK0_HIGH_BIT])
    else $error("write reached a locked upper half");

  low_seg_never_a: assert property (
    mem_wr |-> !(cmd_idx >= `OTQ_LOW_SEG_FIRST && cmd_idx < `OTQ_HIGH_SEG_FIRST))
    else $error("factory number was written");

  // ************************************************
  // error flags
  // ************************************************
  perr_sticky_a: assert property (
    status_program_error_o && !(wr_en_i && st.mode != OTQ_PROG_DATA && wdata_i[7:0] == `OTQ_CMD_CLEAR_STATUS)
    |=> status_program_error_o)
    else $error("program error dropped without clear");

  clear_flags_a: assert property (
    wr_en_i && st.mode != OTQ_PROG_DATA && wdata_i[7:0] == `OTQ_CMD_CLEAR_STATUS
    |=> !status_program_error_o && !status_lock_error_o)
    else $error("clear status left a flag set");

endmodule // otq_otp_cfi

// file: src/otq_regs.svh
// constants of the one-time register and query block: commands, offsets, reset images, tables
// assumes it is included by bare name from the package and the design modules
//
// Function
// - seventeen one-time registers, each locked separately
// - register 0 halves; lower half holds factory number
// - upper half and sixteen registers delivered blank
// - programmed bits stay; repeated programs clear more
// - lock bit per register, irreversible, read-only
// - identifier command then read at register offset
// - register reads return sixteen bits each
// - user data programmed sixteen bits per operation
// - program command outside region sets program error
// - locked register program sets both errors, unchanged
// - lock words at 0x80 and 0x89 via program
// - lock word 0 bit 0 factory, bit 1 user
// - lock word 1 bit n locks register n+1
// - query bytes on low byte, upper byte zero
// - query offsets are word addresses, string at 10h
// - offsets 10h-12h return Q, R, Y
// - sections at 10h, 1Bh, 27h, extended table pointed
// - 13h-1Ah hold identifier and pointer byte pairs
// - zero alternate identifier means none exists
`ifndef OTQ_REGS_SVH
`define OTQ_REGS_SVH

// ************************************************
// commands (low data byte of a bus write)
// ************************************************
`define OTQ_CMD_READ_ARRAY 8'hFF
`define OTQ_CMD_READ_ID 8'h90
`define OTQ_CMD_READ_QUERY 8'h98
`define OTQ_CMD_READ_STATUS 8'h70
`define OTQ_CMD_CLEAR_STATUS 8'h50
`define OTQ_CMD_PROGRAM_OTP 8'hC0

// ************************************************
// one-time region map, word offsets from the region base
// ************************************************
`define OTQ_REGION_BASE 16'h0000
`define OTQ_LOCK0_OFS 16'h0080
`define OTQ_LOCK1_OFS 16'h0089
`define OTQ_OTP_LAST_OFS 16'h0109
`define OTQ_MEM_WORDS 138
`define OTQ_LOCK0_IDX 8'h00
`define OTQ_LOW_SEG_FIRST 8'h01
`define OTQ_HIGH_SEG_FIRST 8'h05
`define OTQ_LOCK1_IDX 8'h09
`define OTQ_UPPER_FIRST 8'h0A
`define OTQ_LOCK0_LOW_BIT 0
`define OTQ_LOCK0_HIGH_BIT 1
`define OTQ_LOCK0_RESET 16'hFFFE
`define OTQ_BLANK 16'hFFFF
`define OTQ_ARRAY_READ 16'hFFFF

// ************************************************
// status word
// ************************************************
`define OTQ_SR_READY_BIT 7
`define OTQ_SR_PROG_ERR_BIT 4
`define OTQ_SR_LOCK_ERR_BIT 1

// ************************************************
// query database, byte k answers offset 10h + k
// ************************************************
`define OTQ_CFI_FIRST 16'h0010
`define OTQ_CFI_LAST 16'h002B
`define OTQ_CFI_GEOM 16'h0027
`define OTQ_CFI_TABLE 224'h000A_0001_0000_0202_0100_0A0A_0995_8536_2300_0000_0001_0A00_0159_5251

`endif

// file: src/otq_pkg.sv
// types shared by the one-time register and query block
// assumes otq_regs.svh is on the include path
`include "otq_regs.svh"

package otq_pkg;

  typedef enum logic [2:0] {
    OTQ_ARRAY = 3'b000,
    OTQ_IDENT = 3'b001,
    OTQ_QUERY = 3'b010,
    OTQ_STATUS = 3'b011,
    OTQ_PROG_DATA = 3'b100
  } otq_mode_t;

  typedef struct packed {
    otq_mode_t mode;
    logic [15:0] cmd_addr;
    logic bad;
    logic prog_err;
    logic lock_err;
    logic [15:0] rdata;
    logic rvalid;
  } otq_state_t;

  typedef struct packed {
    logic [`OTQ_MEM_WORDS-1:0][15:0] word;
  } otq_store_t;

endpackage : otq_pkg

// file: src/otq_store.sv
// one-time word store: two lock words and the seventeen registers, bits only clear
// assumes the caller keeps indices below the store size and checks locks itself
`include "otq_regs.svh"

module otq_store import otq_pkg::*; #(
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [7:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [15:0] rdata_o,
  output logic [15:0] lock0_o,
  output logic [15:0] lock1_o
);

  otq_store_t st;
  otq_store_t next_st;
  otq_store_t image;

  // ************************************************
  // delivery image
  // ************************************************
  // the store stands in for nonvolatile cells, so reset reloads the delivery image
  for (genvar i = 0; i < `OTQ_MEM_WORDS; i++) begin : g_image
    if (i == 0) begin : g_lock0
      assign image.word[i] = `OTQ_LOCK0_RESET;
    end else if (i < 5) begin : g_uid
      assign image.word[i] = UNIQUE_ID[16*(i-1) +: 16];
    end else begin : g_blank
      assign image.word[i] = `OTQ_BLANK;
    end
  end

  always_comb begin
    next_st = st;
    if (wr_i) begin
      next_st.word[waddr_i] = st.word[waddr_i] & wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= image;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.word[raddr_i];
  assign lock0_o = st.word[`OTQ_LOCK0_IDX];
  assign lock1_o = st.word[`OTQ_LOCK1_IDX];

  bits_only_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_i |=> st.word[$past(waddr_i)] == ($past(st.word[waddr_i]) & $past(wdata_i)))
    else $error("programmed word is not the and of old and new data");

endmodule // otq_store

// file: verification/otq_host_model.sv
// host on the strobe bus of the one-time register and query block
// assumes the bench calls its tasks one at a time from a single process
module otq_host_model (
  input wire logic ref_clk_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i,
  input wire logic rdata_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end

  // ************************************************
  // bus cycles
  // ************************************************
  // released lines flip so a stale value never passes for a live one
  task automatic drop();
    wr_en_o <= 1'b0;
    rd_en_o <= 1'b0;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask

  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    drop();
  endtask

  // answer is registered on the taking edge itself and sampled just after it
  task automatic read(input logic [15:0] a, output logic [15:0] d, output logic ok);
    @(posedge ref_clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    drop();
    #1;
    ok = rdata_valid_i;
    d = rdata_i;
  endtask

  // command and data go to the same word address
  task automatic prog_word(input logic [15:0] a, input logic [15:0] d);
    write(a, 16'h00C0);
    write(a, d);
  endtask
endmodule // otq_host_model

// file: verification/tb.sv
// self-checking bench for the one-time register and query block
// assumes the host model drives the bus and the bench keeps an image of the store
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] UID = 64'hA5C3_1E2F_7B90_4D68; // arbitrary factory number
  localparam logic [7:0] DENS = 8'h1A;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en;
  logic rd_en;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rdata_valid;
  logic prog_err;
  logic lock_err;
  logic [15:0] img [0:137];
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int r;

  always #5 ref_clk = ~ref_clk;

  otq_host_model host (.ref_clk_i(ref_clk), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata), .rdata_valid_i(rdata_valid));

  otq_otp_cfi #(.DENSITY_LOG2(DENS), .UNIQUE_ID(UID)) dut (.ref_clk_i(ref_clk), .rst_i(rst),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .rdata_valid_o(rdata_valid), .status_program_error_o(prog_err), .status_lock_error_o(lock_err));

  // ************************************************
  // reporting
  // ************************************************
  task automatic finish_test();
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [1:0] exp, input string what);
    #1;
    chk_word({14'h0000, prog_err, lock_err}, {14'h0000, exp}, what);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic [15:0] mask);
    logic [15:0] d;
    logic ok;
    host.read(a, d, ok);
    chk_word({15'h0000, ok}, 16'h0001, "read answer");
    chk_word(d & mask, exp, "read data");
  endtask

  // ************************************************
  // expectations
  // ************************************************
  function automatic logic [15:0] exp_query(input int o);
    case (o)
      16: return 16'h0051;
      17: return 16'h0052;
      18: return 16'h0059;
      19: return 16'h0001;
      21: return 16'h000A;
      22: return 16'h0001;
      27: return 16'h0023;
      39: return {8'h00, DENS};
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic locked(input int w);
    if (w >= 1 && w <= 4) return !img[0][0];
    if (w >= 5 && w <= 8) return !img[0][1];
    if (w >= 10) return !img[9][(w - 10) / 8];
    return 1'b0;
  endfunction

  // lock words themselves always take more cleared bits
  task automatic prog(input logic [15:0] a, input logic [15:0] d);
    int w;
    logic [1:0] ef;
    w = int'(a) - 128;
    ef = 2'b00;
    if (w < 0 || w > 137) begin
      ef = 2'b10;
    end else if (locked(w)) begin
      ef = 2'b11;
    end else begin
      img[w] = img[w] & d;
    end
    host.prog_word(a, d);
    chk_flags(ef, "program flags");
    host.write(16'h0000, 16'h0070);
    rd_chk(16'h0000, {8'h00, 1'b1, 2'b00, ef[1], 2'b00, ef[0], 1'b0}, 16'h0092);
    host.write(16'h0000, 16'h0050);
    chk_flags(2'b00, "flags cleared");
  endtask

  task automatic verify_all();
    host.write(16'h0080, 16'h0090);
    for (int w = 0; w < 138; w++) begin
      rd_chk(16'(w + 128), img[w], 16'hFFFF);
    end
  endtask

  // ************************************************
  // sequence
  // ************************************************
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    foreach (img[i]) img[i] = 16'hFFFF;
    img[0] = 16'hFFFE;
    for (int i = 0; i < 4; i++) img[i + 1] = UID[16 * i +: 16];
    void'($urandom(32'h7355));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    host.write(16'h0123, 16'h0098);
    for (int o = 16; o < 40; o++) begin
      if (o < 28 || o == 39) rd_chk(16'(o), exp_query(o), 16'hFFFF);
    end
    host.write(16'h0000, 16'h00FF);
    rd_chk(16'h0081, 16'hFFFF, 16'hFFFF);
    verify_all();
    prog(16'h007F, 16'h0000);
    prog(16'h010A, 16'h0000);
    prog(16'h0081, 16'h0000);
    prog(16'h0092, 16'hF0F0);
    prog(16'h0092, 16'hFF00);
    prog(16'h0089, 16'hFFF7);
    prog(16'h00A2, 16'h0000);
    prog(16'h0089, 16'hFFFF);
    prog(16'h00A3, 16'h1234);
    prog(16'h0080, 16'hFFFD);
    prog(16'h0085, 16'h0000);
    verify_all();
    repeat (40) begin
      r = $urandom_range(0, 140);
      prog(16'(128 + r), 16'($urandom));
    end
    verify_all();
    finish_test();
  end
endmodule // tb
